// File: slwm_link.sv
// Serial link wire-mode control with key scan timing and request signalling
module slwm_link #(
    parameter int SCAN_CYC = slwm_pkg::SCAN_CYC    // Cycles of one agreeing scan
) (
    input  wire logic                     ref_clk_i,           // Core clock, 10 MHz
    input  wire logic                     srst_i,              // Synchronous reset, high
    input  wire logic                     link_clk_i,          // Serial clock from host
    input  wire logic                     ce_i,                // Chip enable, link domain
    input  wire logic                     host_to_chip_line_i, // Serial input wire level
    input  wire logic                     three_wire_i,        // Mode strap, high = shared line
    input  wire logic [slwm_pkg::KEY_N-1:0] keys_i,            // Raw key inputs, async
    input  wire logic                     sleep_ack_bit_i,     // Sleep state, core domain
    output logic                          sio_o,               // Shared line drive value
    output logic                          sio_oe_n_o,          // Shared line enable, low drives
    output logic                          do_o,                // Output pin drive value
    output logic                          do_oe_n_o,           // Output pin enable, low drives
    output logic                          key_pending_o,       // Report waiting for the host
    output logic                          key_stall_o          // Scan held by a full buffer
);
    localparam int W = slwm_pkg::WORD_W;
    localparam int CW = slwm_pkg::SCAN_CNT_W;

    // ---------------- Core domain ----------------
    logic [slwm_pkg::KEY_N-1:0] key_m_r, key_s_r, snap_r, snap_nxt, last_r, last_nxt;
    logic [1:0]  ce_c_r, st_c_r, tw_c_r;   // Two-stage synchronisers, bit 0 first
    logic [2:0]  done_c_r;                 // Toggle synchroniser plus edge stage
    logic        started_r, started_nxt, done_tgl_r, done_nxt, rdv_r, rdv_nxt;
    slwm_pkg::slwm_scan_t scan_r, scan_nxt;
    logic [slwm_pkg::SCAN_CNT_W-1:0] cnt_r, cnt_nxt;
    logic        req_r, req_nxt;
    logic        buf_in_ready, buf_out_valid, pop;
    logic [W-1:0] buf_out_data;

    assign pop = done_c_r[2] ^ done_c_r[1];

    // Scan control: change seen, scan, rescan on disagreement, then report
    always_comb begin
        scan_nxt = scan_r;
        cnt_nxt  = cnt_r + 1'b1;
        snap_nxt = snap_r;
        last_nxt = last_r;
        case (scan_r)
            slwm_pkg::SLWM_S_IDLE: begin
                cnt_nxt = '0;
                if (key_s_r != last_r) begin
                    scan_nxt = slwm_pkg::SLWM_S_SCAN1;
                    snap_nxt = key_s_r;
                end
            end
            slwm_pkg::SLWM_S_SCAN1: begin
                if (cnt_r == CW'(SCAN_CYC - 1)) begin
                    cnt_nxt = '0;
                    if (key_s_r == snap_r) begin
                        scan_nxt = slwm_pkg::SLWM_S_PUSH;
                    end else begin
                        scan_nxt = slwm_pkg::SLWM_S_SCAN2;
                        snap_nxt = key_s_r;
                    end
                end
            end
            slwm_pkg::SLWM_S_SCAN2: begin
                if (cnt_r == CW'(SCAN_CYC - 1)) begin
                    cnt_nxt  = '0;
                    scan_nxt = slwm_pkg::SLWM_S_PUSH;
                end
            end
            slwm_pkg::SLWM_S_PUSH: begin
                cnt_nxt = '0;
                if (buf_in_ready) begin
                    scan_nxt = slwm_pkg::SLWM_S_IDLE;
                    last_nxt = snap_r;
                end
            end
            default: begin
                scan_nxt = slwm_pkg::SLWM_S_IDLE;
                cnt_nxt  = '0;
            end
        endcase
        // Request pulls the line low only while CE is low; in shared mode only while not started (after reset, stop or a finished read)
        req_nxt = buf_out_valid & ~ce_c_r[1] & ~pop
                & (~tw_c_r[1] | ~st_c_r[1]);
    end

    // Core registers; synchronisers read only by their second stage
    always_ff @(posedge ref_clk_i) begin
        key_m_r  <= keys_i;
        key_s_r  <= key_m_r;
        ce_c_r   <= {ce_c_r[0], ce_i};
        st_c_r   <= {st_c_r[0], started_r};
        tw_c_r   <= {tw_c_r[0], three_wire_i};
        done_c_r <= {done_c_r[1], done_c_r[0], done_tgl_r};
        snap_r   <= snap_nxt;
        if (srst_i) begin
            scan_r <= slwm_pkg::SLWM_S_IDLE;
            cnt_r  <= '0;
            last_r <= '0;
            req_r  <= 1'b0;
        end else begin
            scan_r <= scan_nxt;
            cnt_r  <= cnt_nxt;
            last_r <= last_nxt;
            req_r  <= req_nxt;
        end
    end

    // Reports wait here; a slow reader stalls the scanner instead of losing one
    slwm_buf2 #(.W(W)) u_buf (
        .ref_clk_i   (ref_clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (scan_r == slwm_pkg::SLWM_S_PUSH),
        .in_ready_o  (buf_in_ready),
        .in_data_i   ({sleep_ack_bit_i, snap_r}),
        .out_valid_o (buf_out_valid),
        .out_ready_i (pop),
        .out_data_o  (buf_out_data)
    );

    assign key_pending_o = buf_out_valid;
    assign key_stall_o   = (scan_r == slwm_pkg::SLWM_S_PUSH) & ~buf_in_ready;

    // ---------------- Link domain ----------------
    logic [1:0]  rst_l_r, pv_l_r, tw_l_r;
    logic        link_rst;
    slwm_pkg::slwm_link_t ph_r, ph_nxt;
    logic        ce_q_r;
    logic [5:0]  bit_r, bit_nxt;
    logic [7:0]  adr_r, adr_nxt;
    logic [W-1:0] osh_r, osh_nxt;
    logic        rd_drive, req_drive;

    assign link_rst = rst_l_r[1];

    // Frame decode: address bits with CE low, data with CE high, LSB first
    always_comb begin
        ph_nxt      = ph_r;
        bit_nxt     = bit_r;
        adr_nxt     = adr_r;
        osh_nxt     = osh_r;
        started_nxt = started_r;
        done_nxt    = done_tgl_r;
        rdv_nxt     = rdv_r;
        if (!ce_i) begin
            if (ce_q_r || ph_r != slwm_pkg::SLWM_L_ADDR) begin
                ph_nxt  = slwm_pkg::SLWM_L_ADDR;
                bit_nxt = 6'h01;
                adr_nxt = {host_to_chip_line_i, 7'h00};
            end else if (bit_r < 6'(slwm_pkg::ADDR_BITS)) begin
                adr_nxt = {host_to_chip_line_i, adr_r[7:1]};
                bit_nxt = bit_r + 6'h01;
            end
        end else if (!ce_q_r && ph_r == slwm_pkg::SLWM_L_ADDR
                     && bit_r == 6'(slwm_pkg::ADDR_BITS)) begin
            bit_nxt = '0;
            ph_nxt  = slwm_pkg::SLWM_L_IDLE;
            case (adr_r)
                slwm_pkg::ADDR_START: started_nxt = 1'b1;
                slwm_pkg::ADDR_STOP:  started_nxt = 1'b0;
                slwm_pkg::ADDR_WRITE: ph_nxt = slwm_pkg::SLWM_L_WRITE;
                slwm_pkg::ADDR_READ: begin
                    ph_nxt  = slwm_pkg::SLWM_L_READ;
                    rdv_nxt = pv_l_r[1];
                    // With no report waiting the report is forced to zero
                    osh_nxt = pv_l_r[1] ? buf_out_data : '0;
                end
                default: ph_nxt = slwm_pkg::SLWM_L_IDLE;
            endcase
        end else if (ph_r == slwm_pkg::SLWM_L_READ) begin
            osh_nxt = {1'b1, osh_r[W-1:1]};
            bit_nxt = bit_r + 6'h01;
            if (bit_r == 6'(W - 1)) begin
                ph_nxt      = slwm_pkg::SLWM_L_IDLE;
                started_nxt = 1'b0;
                done_nxt    = done_tgl_r ^ rdv_r;
            end
        end
    end

    // Link registers; report data is read only while its valid level is stable
    always_ff @(posedge link_clk_i) begin
        rst_l_r <= {rst_l_r[0], srst_i};
        pv_l_r  <= {pv_l_r[0], buf_out_valid};
        tw_l_r  <= {tw_l_r[0], three_wire_i};
        ce_q_r  <= ce_i;
        adr_r   <= adr_nxt;
        osh_r   <= osh_nxt;
        if (link_rst) begin
            ph_r       <= slwm_pkg::SLWM_L_IDLE;
            bit_r      <= '0;
            started_r  <= 1'b0;
            done_tgl_r <= 1'b0;
            rdv_r      <= 1'b0;
        end else begin
            ph_r       <= ph_nxt;
            bit_r      <= bit_nxt;
            started_r  <= started_nxt;
            done_tgl_r <= done_nxt;
            rdv_r      <= rdv_nxt;
        end
    end

    // Pin routing: open drain, value always low, enable carries the data
    assign rd_drive   = (ph_r == slwm_pkg::SLWM_L_READ) & ~osh_r[0];
    // Request leaves the wire as soon as a frame starts; the core copy lags by cycles
    assign req_drive  = req_r & ~ce_i & ~(tw_l_r[1] & started_r)
                      & ~(ph_r == slwm_pkg::SLWM_L_ADDR && bit_r != '0);
    assign sio_o      = 1'b0;
    assign do_o       = 1'b0;
    assign sio_oe_n_o = ~(tw_l_r[1] & (rd_drive | req_drive));
    assign do_oe_n_o  = ~(~tw_l_r[1] & (rd_drive | req_drive));

    // ---------------- Checks ----------------
    logic [slwm_pkg::SCAN_CNT_W:0] scan_age_r;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || scan_r == slwm_pkg::SLWM_S_IDLE) begin
            scan_age_r <= '0;
        end else if (scan_r != slwm_pkg::SLWM_S_PUSH) begin
            scan_age_r <= scan_age_r + 1'b1;
        end
    end

    property p_scan_time;
        @(posedge ref_clk_i) disable iff (srst_i)
        $rose(scan_r == slwm_pkg::SLWM_S_PUSH) |->
            (scan_age_r == (slwm_pkg::SCAN_CNT_W + 1)'(SCAN_CYC)
             || scan_age_r == (slwm_pkg::SCAN_CNT_W + 1)'(2 * SCAN_CYC));
    endproperty
    a_scan_time: assert property (p_scan_time) else $error("scan length wrong");

    property p_req_drive;
        @(posedge ref_clk_i) disable iff (srst_i)
        (buf_out_valid && !ce_c_r[1] && !tw_c_r[1] && !pop) |=> req_r;
    endproperty
    a_req_drive: assert property (p_req_drive) else $error("request not driven");

    property p_req_quiet;
        @(posedge ref_clk_i) disable iff (srst_i)
        req_r |-> $past(!ce_c_r[1] && buf_out_valid && !(tw_c_r[1] && st_c_r[1]));
    endproperty
    a_req_quiet: assert property (p_req_quiet) else $error("request driven wrongly");

    property p_invalid_read;
        @(posedge link_clk_i) disable iff (link_rst)
        (ph_r == slwm_pkg::SLWM_L_READ && !rdv_r) |-> (osh_r == '0 || bit_r != '0);
    endproperty
    a_invalid_read: assert property (p_invalid_read) else $error("bad data on idle read");

    property p_read_stops;
        @(posedge link_clk_i) disable iff (link_rst)
        (ph_r == slwm_pkg::SLWM_L_READ && ce_i && bit_r == 6'(W - 1))
            |=> (!started_r && ph_r == slwm_pkg::SLWM_L_IDLE) ##1 sio_oe_n_o || !ce_i;
    endproperty
    a_read_stops: assert property (p_read_stops) else $error("read did not stop");

    property p_four_wire;
        @(posedge link_clk_i) disable iff (link_rst)
        tw_l_r[1] |-> do_oe_n_o;
    endproperty
    a_four_wire: assert property (p_four_wire) else $error("output pin used in shared mode");

    c_rescan: cover property (@(posedge ref_clk_i) disable iff (srst_i)
        scan_r == slwm_pkg::SLWM_S_SCAN2);
    c_stall: cover property (@(posedge ref_clk_i) disable iff (srst_i) key_stall_o);
    c_read: cover property (@(posedge link_clk_i) disable iff (link_rst)
        ph_r == slwm_pkg::SLWM_L_READ && rdv_r);
endmodule

// File: slwm_pkg.sv
// Constants, states and timing shared by the serial link wire-mode block
package slwm_pkg;
    localparam int          KEY_N         = 35;
    localparam int          WORD_W        = KEY_N + 1;
    localparam logic [7:0]  ADDR_WRITE    = 8'h42;
    localparam logic [7:0]  ADDR_READ     = 8'h43;
    localparam logic [7:0]  ADDR_START    = 8'h4A;
    localparam logic [7:0]  ADDR_STOP     = 8'h4B;
    localparam int          ADDR_BITS     = 8;
    localparam int          SCAN_AGREE_T  = 4800;   // Scan time in oscillator periods
    localparam int          SCAN_RETRY_T  = 9600;   // Scan time when repeated
    localparam int          OSC_PERIOD_NS = 100;    // Oscillator period, one core clock
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          SCAN_CYC      = SCAN_AGREE_T * OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int          SCAN_CNT_W    = 15;
    typedef enum logic [1:0] {SLWM_S_IDLE, SLWM_S_SCAN1, SLWM_S_SCAN2, SLWM_S_PUSH} slwm_scan_t;
    typedef enum logic [1:0] {SLWM_L_ADDR, SLWM_L_WRITE, SLWM_L_READ, SLWM_L_IDLE} slwm_link_t;
endpackage

// File: slwm_buf2.sv
// Two-entry valid/ready buffer holding finished key reports
module slwm_buf2 #(
    parameter int W = 36                   // Word width
) (
    input  wire logic         ref_clk_i,   // Core clock
    input  wire logic         srst_i,      // Synchronous reset
    input  wire logic         in_valid_i,  // Word offered
    output logic              in_ready_o,  // Room for a word
    input  wire logic [W-1:0] in_data_i,   // Word in
    output logic              out_valid_o, // Oldest word present
    input  wire logic         out_ready_i, // Oldest word taken
    output logic [W-1:0]      out_data_o   // Oldest word
);
    logic [W-1:0] mem_r [2];
    logic [W-1:0] mem_nxt [2];
    logic         rd_r, rd_nxt, wr_r, wr_nxt;
    logic [1:0]   cnt_r, cnt_nxt;
    logic         push, pop;

    // Handshakes; full and empty come straight from the fill count
    assign in_ready_o  = (cnt_r != 2'h2);
    assign out_valid_o = (cnt_r != 2'h0);
    assign out_data_o  = mem_r[rd_r];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_ready_i & out_valid_o;

    // Next pointers, count and storage
    always_comb begin
        mem_nxt = mem_r;
        if (push) begin
            mem_nxt[wr_r] = in_data_i;
        end
        wr_nxt  = push ? ~wr_r : wr_r;
        rd_nxt  = pop ? ~rd_r : rd_r;
        cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    end

    // Registers only
    always_ff @(posedge ref_clk_i) begin
        mem_r <= mem_nxt;
        if (srst_i) begin
            rd_r  <= 1'b0;
            wr_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            rd_r  <= rd_nxt;
            wr_r  <= wr_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// File: slwm_host.sv
// Host model that frames the serial link and reads the line level
module slwm_host (
    output logic      link_clk_o,   // Link clock, still outside frames except when run during reset
    output logic      ce_o,         // Chip enable
    output logic      line_o,       // Level seen at the serial input
    input  wire logic three_wire_i, // Wiring variant
    input  wire logic sio_i,        // Shared line value
    input  wire logic sio_oe_n_i,   // Shared line enable, low drives
    input  wire logic do_i,         // Output pin value
    input  wire logic do_oe_n_i     // Output pin enable, low drives
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hd_r;
    int   coll_n;
    // Pull-up wire: host and device both only pull low
    wire  shared_lvl = hd_r & (sio_oe_n_i | sio_i);
    assign line_o = three_wire_i ? shared_lvl : hd_r;
    initial begin
        link_clk_o = 1'b0;
        ce_o = 1'b0;
        hd_r = 1'b1;
        coll_n = 0;
    end
    // Line level; the request while enable is low, low means pending; a report bit during a read
    function automatic logic rd_lvl();
        return three_wire_i ? shared_lvl : (do_oe_n_i | do_i);
    endfunction
    // One 6 ns link clock cycle
    task automatic pulse();
        #3 link_clk_o = 1'b1;
        #3 link_clk_o = 1'b0;
    endtask
    task automatic run(input int n);
        repeat (n) pulse();
    endtask
    // Address LSB first, then n data bits or a 36-bit read
    task automatic xfer(input logic [7:0] a, input int n, input logic [35:0] wd,
                        input logic rd_en, output logic [35:0] rd);
        rd = '0;
        ce_o = 1'b0;
        for (int i = 0; i < 8; i++) begin
            hd_r = a[i];
            pulse();
        end
        ce_o = 1'b1;
        hd_r = 1'b1;
        pulse();
        for (int i = 0; i < n; i++) begin
            hd_r = wd[i];
            if (three_wire_i && sio_oe_n_i === 1'b0) coll_n++;  // Counted, never expected
            pulse();
        end
        // Released during the read so the pull-up lets the device speak
        for (int i = 0; i < 36 && rd_en; i++) begin
            rd[i] = rd_lvl();   // Line level is the report bit
            pulse();
        end
        ce_o = 1'b0;
        hd_r = 1'b1;
    endtask
endmodule

// File: tb_slwm_link.sv
// Testbench of the serial link wire-mode block
module tb_slwm_link;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC = 20;
    logic                       ref_clk_i = 1'b0;
    logic                       srst_i = 1'b1;
    logic                       three_wire_i = 1'b0;
    logic [slwm_pkg::KEY_N-1:0] keys_i = '0;
    logic                       sleep_ack_bit_i = 1'b0;
    logic link_clk, ce, line, sio, sio_oe_n, do_v, do_oe_n, pend, stall;
    logic [35:0] rd;
    int err_total = 0;
    int n_compared = 0;
    int cyc_n = 0;
    int c;
    initial forever #50 ref_clk_i = ~ref_clk_i;
    slwm_link #(.SCAN_CYC(SC)) i_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .link_clk_i(link_clk), .ce_i(ce), .host_to_chip_line_i(line),
        .three_wire_i(three_wire_i), .keys_i(keys_i), .sleep_ack_bit_i(sleep_ack_bit_i),
        .sio_o(sio), .sio_oe_n_o(sio_oe_n), .do_o(do_v), .do_oe_n_o(do_oe_n),
        .key_pending_o(pend), .key_stall_o(stall));
    slwm_host i_host (.link_clk_o(link_clk), .ce_o(ce), .line_o(line),
        .three_wire_i(three_wire_i), .sio_i(sio), .sio_oe_n_i(sio_oe_n), .do_i(do_v),
        .do_oe_n_i(do_oe_n));
    task automatic give_verdict();
        if (err_total == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Two-cycle reset; the link clock runs meanwhile so the link flops clear too
    task automatic do_reset(input logic m);
        @(posedge ref_clk_i);
        srst_i <= 1'b1;
        three_wire_i <= m;
        keys_i <= '0;
        @(posedge ref_clk_i);
        i_host.run(8);
        @(posedge ref_clk_i);
        srst_i <= 1'b0;
        i_host.run(2);    // Two edges end the link reset and leave the framer idle
        repeat (2) @(posedge ref_clk_i);
    endtask
    task automatic wait_pend(output int n);
        n = 0;
        while (pend !== 1'b1 && n < 8 * SC) begin
            @(negedge ref_clk_i);   // Mid-cycle, where the fill count has settled
            n++;
        end
    endtask
    // Key read, then a pause longer than a repeated scan
    task automatic key_read(output logic [35:0] r);
        i_host.xfer(slwm_pkg::ADDR_READ, 0, '0, 1'b1, r);
        repeat (2 * SC + 8) @(posedge ref_clk_i);
    endtask
    // Four-wire: agreeing scan time, request low, report bits and pop
    task automatic t_four();
        do_reset(1'b0);
        key_read(rd);
        chk("idle_read", '0, rd);
        @(posedge ref_clk_i);
        sleep_ack_bit_i <= 1'b1;
        keys_i <= 35'h400000001;
        wait_pend(c);
        chk("scan_agree", 1, c >= SC && c <= SC + 8);
        repeat (6) @(posedge ref_clk_i);
        chk("req_low", 0, i_host.rd_lvl());
        chk("sio_idle", 1, sio_oe_n);
        key_read(rd);
        chk("report", {1'b1, 35'h400000001}, rd);
        chk("popped", 0, pend);
        chk("req_gone", 1, i_host.rd_lvl());
    endtask
    // Keys change mid-scan: the repeated scan runs longer
    task automatic t_retry();
        @(posedge ref_clk_i);
        sleep_ack_bit_i <= 1'b0;
        keys_i <= 35'h012345678;
        repeat (SC / 2) @(posedge ref_clk_i);
        keys_i <= 35'h0ABCDE123;
        wait_pend(c);
        c = c + SC / 2;
        chk("scan_retry", 1, c > SC + 8 && c <= 2 * SC + 8);
        key_read(rd);
        chk("report_retry", {1'b0, 35'h0ABCDE123}, rd);
    endtask
    // Three finished scans with no read fill the buffer and hold the third
    task automatic t_full();
        logic [34:0] kv [3];
        kv = '{35'h000000111, 35'h000000222, 35'h000000333};
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk_i);
            keys_i <= kv[i];
            repeat (2 * SC + 10) @(posedge ref_clk_i);
        end
        chk("stall_full", 1, stall);
        for (int i = 0; i < 3; i++) begin
            key_read(rd);
            chk("report_fifo", {1'b0, kv[i]}, rd);
            chk("stall_after", 0, stall);
        end
        chk("drained", 0, pend);
    endtask
    // Three-wire: bracketed write, request after stop, silent after start
    task automatic t_three();
        do_reset(1'b1);
        i_host.xfer(slwm_pkg::ADDR_START, 0, '0, 1'b0, rd);
        i_host.xfer(slwm_pkg::ADDR_WRITE, 36, 36'hF0F0F0F0F, 1'b0, rd);
        i_host.xfer(slwm_pkg::ADDR_STOP, 0, '0, 1'b0, rd);
        chk("collisions", 0, 36'(i_host.coll_n));
        @(posedge ref_clk_i);
        keys_i <= 35'h7FFFFFFFF;
        wait_pend(c);
        repeat (6) @(posedge ref_clk_i);
        chk("req_shared", 0, i_host.rd_lvl());
        i_host.xfer(slwm_pkg::ADDR_START, 0, '0, 1'b0, rd);
        repeat (6) @(posedge ref_clk_i);
        chk("started_quiet", 1, sio_oe_n);
        key_read(rd);
        chk("report_shared", {1'b0, 35'h7FFFFFFFF}, rd);
        chk("released", 1, sio_oe_n);
        chk("do_unused", 1, do_oe_n);
    endtask
    // Cycle ceiling well above the expected run
    always @(posedge ref_clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        t_four();
        t_retry();
        t_full();
        t_three();
        give_verdict();
    end
endmodule
